// ### verilog/pcrc_pkg.sv
// Shared constants and types of the programmable CRC engine
package pcrc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PCRC_DW = 32;             // Data word width
    localparam int PCRC_AW = 8;              // Register address width

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PCRC_OFS_CONFIG = 8'h00;   // crc_config
    localparam logic [7:0] PCRC_OFS_GENERATOR = 8'h04;   // crc_generator
    localparam logic [7:0] PCRC_OFS_INITIAL = 8'h08;   // crc_initial_value
    localparam logic [7:0] PCRC_OFS_FINAL_XOR = 8'h0c;   // crc_final_xor
    localparam logic [7:0] PCRC_OFS_INPUT = 8'h10;   // crc_input_word
    localparam logic [7:0] PCRC_OFS_RESULT = 8'h14;   // crc_result_word

    // ------------------------------------------------------------
    // crc_config field positions
    // ------------------------------------------------------------
    localparam int PCRC_CFG_WIDTH_LSB = 0;   // input_width_select [1:0]
    localparam int PCRC_CFG_IN_ORDER_LSB = 2;   // input_order_select [1:0]
    localparam int PCRC_CFG_OUT_ORDER_LSB = 4;   // output_order_select [1:0]
    localparam int PCRC_CFG_IRQ_EN_BIT = 6;   // Completion interrupt enable
    localparam int PCRC_CFG_DONE_BIT = 7;   // Sticky done flag, write 1 clears
    localparam int PCRC_CFG_BUSY_BIT = 8;   // Step in progress, read only

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] PCRC_RST_WORD = 32'h0000_0000;  // All word registers
    localparam logic [1:0] PCRC_RST_FIELD = 2'h0;  // All select fields
    localparam logic PCRC_RST_BIT = 1'b0;  // Enable and flag

    // ------------------------------------------------------------
    // Timing: a step lasts 8 cycles per byte plus this overhead
    // ------------------------------------------------------------
    localparam int PCRC_STEP_OVERHEAD = 2;   // Convert cycle and finish cycle

    // ------------------------------------------------------------
    // Order selection codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PCRC_MSB_BIG = 2'b00,
        PCRC_MSB_LITTLE = 2'b01,
        PCRC_LSB_BIG = 2'b10,
        PCRC_LSB_LITTLE = 2'b11
    } pcrc_order_t;

endpackage

// ### verilog/pcrc_if.sv
// Register bus between the CRC engine and its processor or DMA master
`timescale 1ns/1ps
interface pcrc_if;
    logic [7:0] addr;     // Register byte address
    logic [31:0] wdata;   // Write data
    logic wr;             // Write strobe, one cycle
    logic rd;             // Read strobe, one cycle
    logic [31:0] rdata;   // Read data, cycle after rd
    logic irq;            // Completion interrupt request

    // Engine end
    modport dev (input addr, input wdata, input wr, input rd, output rdata, output irq);
    // Processor or DMA end
    modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// ### verilog/pcrc_device.sv
// Programmable CRC engine: register slave, order conversion and LFSR
//
// Behaviour
// - Programmable generator polynomial, length up to 32
// - Input width selectable as 8/16/24/32 bits
// - Successive words extend the running CRC
// - Input word reordered by four bit/byte orders
// - LFSR result reordered by four bit/byte orders
// - Calculation starts from software initial value
// - Result combined with software final xor value
// - Interrupt request raised when a step finishes
// - DMA or processor writes both feed input
// - One config register: mode and busy status
// - Software loads generator before first input word
// - Software loads initial value before first word
// - Final xor loaded first, applied only finally
// - Write-only input register launches each step
// - Readable result register holds converted result
// - Size and order fields steer input conversion
// - Busy flag set at start, cleared at end
// - Step takes 10/18/26/34 cycles by size
// - Output conversion first, then final xor
// - Order codes: MSB/LSB first, big/little endian
`timescale 1ns/1ps
module pcrc_device
    import pcrc_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    pcrc_if.dev BUS,
    output logic IRQ,
    output logic BUSY
);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,   // Waiting for an input word
        DS_PREP = 2'b01,   // Input conversion
        DS_SHIFT = 2'b10,  // One bit per cycle through the LFSR
        DS_DONE = 2'b11    // Output conversion and final xor
    } pcrc_dst_t;

    typedef struct packed {
        pcrc_dst_t st;       // Step sequencer
        logic [1:0] wsel;    // input_width_select
        logic [1:0] isel;    // input_order_select
        logic [1:0] osel;    // output_order_select
        logic ien;           // Interrupt enable
        logic done;          // Sticky step-done flag
        logic [31:0] gen;    // crc_generator, top aligned
        logic [31:0] init;   // crc_initial_value
        logic [31:0] fxor;   // crc_final_xor
        logic [31:0] lfsr;   // Running CRC
        logic [31:0] shw;    // Converted input, shifted out MSB first
        logic [4:0] cnt;     // Remaining shift cycles minus one
        logic [31:0] result; // crc_result_word
        logic [31:0] rdata;  // Read data register
    } pcrc_dreg_t;

    pcrc_dreg_t q;   // Registered state
    pcrc_dreg_t d;   // Next state

    // ------------------------------------------------------------
    // Reordering helpers
    // ------------------------------------------------------------
    // Reverse the bits inside each byte
    function automatic logic [31:0] bit_rev_bytes(input logic [31:0] w);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++)
        begin
            r[(i / 8) * 8 + 7 - (i % 8)] = w[i];
        end
        return r;
    endfunction

    // Reverse the byte order of the word
    function automatic logic [31:0] byte_swap(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // Apply an order code to a top-aligned word
    function automatic logic [31:0] reorder(input logic [31:0] w, input logic [1:0] sel);
        logic [31:0] r;
        r = sel[0] ? byte_swap(w) : w;            // Little endian
        r = sel[1] ? bit_rev_bytes(r) : r;        // LSB first
        return r;
    endfunction

    // Current crc_config read value
    function automatic logic [31:0] config_word(input pcrc_dreg_t s);
        logic [31:0] r;
        r = '0;
        r[PCRC_CFG_WIDTH_LSB +: 2] = s.wsel;
        r[PCRC_CFG_IN_ORDER_LSB +: 2] = s.isel;
        r[PCRC_CFG_OUT_ORDER_LSB +: 2] = s.osel;
        r[PCRC_CFG_IRQ_EN_BIT] = s.ien;
        r[PCRC_CFG_DONE_BIT] = s.done;
        r[PCRC_CFG_BUSY_BIT] = (s.st != DS_IDLE);
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Bus access first, sequencer last so a hardware set wins a clear
    always_comb
    begin
        logic fb;
        logic [4:0] shamt;
        fb = 1'b0;
        shamt = '0;
        d = q;
        d.rdata = '0;

        // Register reads, data stand in the following cycle
        if (BUS.rd)
        begin
            unique case (BUS.addr)
                PCRC_OFS_CONFIG: d.rdata = config_word(q);
                PCRC_OFS_GENERATOR: d.rdata = q.gen;
                PCRC_OFS_INITIAL: d.rdata = q.init;
                PCRC_OFS_FINAL_XOR: d.rdata = q.fxor;
                PCRC_OFS_RESULT: d.rdata = q.result;
                default: d.rdata = '0;   // Input word and unmapped read zero
            endcase
        end

        // Register writes from processor or DMA alike
        if (BUS.wr)
        begin
            unique case (BUS.addr)
                PCRC_OFS_CONFIG:
                begin
                    d.wsel = BUS.wdata[PCRC_CFG_WIDTH_LSB +: 2];
                    d.isel = BUS.wdata[PCRC_CFG_IN_ORDER_LSB +: 2];
                    d.osel = BUS.wdata[PCRC_CFG_OUT_ORDER_LSB +: 2];
                    d.ien = BUS.wdata[PCRC_CFG_IRQ_EN_BIT];
                    if (BUS.wdata[PCRC_CFG_DONE_BIT])
                    begin
                        d.done = 1'b0;   // Write one clears the flag
                    end
                end
                PCRC_OFS_GENERATOR: d.gen = BUS.wdata;
                PCRC_OFS_INITIAL:
                begin
                    d.init = BUS.wdata;
                    if (q.st == DS_IDLE)
                    begin
                        d.lfsr = BUS.wdata;   // Seed the running CRC
                    end
                end
                PCRC_OFS_FINAL_XOR: d.fxor = BUS.wdata;
                PCRC_OFS_INPUT:
                begin
                    // Words during a step are dropped
                    if (q.st == DS_IDLE)
                    begin
                        d.shw = BUS.wdata;
                        d.st = DS_PREP;
                    end
                end
                default: ;   // Unmapped writes ignored
            endcase
        end

        // Step sequencer
        unique case (q.st)
            DS_IDLE: ;
            DS_PREP:
            begin
                // Top-align the used bytes, little endian swaps instead
                shamt = {~q.wsel, 3'b000};
                d.shw = q.isel[0] ? reorder(q.shw, q.isel)
                                  : reorder(q.shw << shamt, q.isel);
                d.cnt = {q.wsel, 3'b111};   // Eight shifts per byte
                d.st = DS_SHIFT;
            end
            DS_SHIFT:
            begin
                // MSB-first LFSR on the top-aligned generator
                fb = q.lfsr[31] ^ q.shw[31];
                d.lfsr = {q.lfsr[30:0], 1'b0} ^ (fb ? q.gen : '0);
                d.shw = {q.shw[30:0], 1'b0};
                d.cnt = q.cnt - 5'h1;
                if (q.cnt == '0)
                begin
                    d.st = DS_DONE;
                end
            end
            DS_DONE:
            begin
                d.result = reorder(q.lfsr, q.osel) ^ q.fxor;
                d.done = 1'b1;   // Set wins over a same-cycle clear
                d.st = DS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            q.st <= DS_IDLE;
            q.wsel <= PCRC_RST_FIELD;
            q.isel <= PCRC_RST_FIELD;
            q.osel <= PCRC_RST_FIELD;
            q.ien <= PCRC_RST_BIT;
            q.done <= PCRC_RST_BIT;
            q.gen <= PCRC_RST_WORD;
            q.init <= PCRC_RST_WORD;
            q.fxor <= PCRC_RST_WORD;
            q.lfsr <= PCRC_RST_WORD;
            q.shw <= PCRC_RST_WORD;
            q.cnt <= '0;
            q.result <= PCRC_RST_WORD;
            q.rdata <= PCRC_RST_WORD;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign BUS.rdata = q.rdata;
    assign BUS.irq = q.done & q.ien;   // Held until cleared or disabled
    assign IRQ = q.done & q.ien;
    assign BUSY = (q.st != DS_IDLE);

endmodule

// ### verilog/pcrc_host.sv
// Bus master end: forwards user accesses, paces input words on busy
`timescale 1ns/1ps
module pcrc_host
    import pcrc_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    pcrc_if.host BUS,
    input wire logic USR_WR,
    input wire logic USR_RD,
    input wire logic [7:0] USR_ADDR,
    input wire logic [31:0] USR_WDATA,
    output logic USR_READY,
    output logic [31:0] USR_RDATA,
    output logic USR_RVALID,
    output logic USR_IRQ
);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,    // Accepting user requests
        HS_RD_ISS = 3'b001,  // User read strobe on the bus
        HS_RD_CAP = 3'b010,  // User read data on the bus
        HS_POLL = 3'b011,    // Busy poll read on the bus
        HS_CHECK = 3'b100    // Poll data on the bus
    } pcrc_hst_t;

    typedef struct packed {
        pcrc_hst_t st;        // Sequencer
        logic [7:0] addr;     // Bus address
        logic [31:0] wdata;   // Bus write data
        logic wr;             // Bus write strobe
        logic rd;             // Bus read strobe
        logic [31:0] held;    // Input word waiting for the engine
        logic [31:0] rdata;   // Captured user read data
        logic rvalid;         // Read data valid pulse
    } pcrc_hreg_t;

    pcrc_hreg_t q;   // Registered state
    pcrc_hreg_t d;   // Next state

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.wr = 1'b0;
        d.rd = 1'b0;
        d.rvalid = 1'b0;
        unique case (q.st)
            HS_IDLE:
            begin
                if (USR_WR && USR_ADDR == PCRC_OFS_INPUT)
                begin
                    // Input words wait until the engine is idle
                    d.held = USR_WDATA;
                    d.addr = PCRC_OFS_CONFIG;
                    d.rd = 1'b1;
                    d.st = HS_POLL;
                end
                else if (USR_WR)
                begin
                    // Setup writes go out in user order
                    d.addr = USR_ADDR;
                    d.wdata = USR_WDATA;
                    d.wr = 1'b1;
                end
                else if (USR_RD)
                begin
                    d.addr = USR_ADDR;
                    d.rd = 1'b1;
                    d.st = HS_RD_ISS;
                end
            end
            HS_RD_ISS: d.st = HS_RD_CAP;
            HS_RD_CAP:
            begin
                d.rdata = BUS.rdata;
                d.rvalid = 1'b1;
                d.st = HS_IDLE;
            end
            HS_POLL: d.st = HS_CHECK;
            HS_CHECK:
            begin
                if (BUS.rdata[PCRC_CFG_BUSY_BIT])
                begin
                    d.rd = 1'b1;   // Still busy, poll again
                    d.st = HS_POLL;
                end
                else
                begin
                    d.addr = PCRC_OFS_INPUT;   // Feed the word
                    d.wdata = q.held;
                    d.wr = 1'b1;
                    d.st = HS_IDLE;
                end
            end
            default: d.st = HS_IDLE;   // Unused codes recover
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign BUS.addr = q.addr;
    assign BUS.wdata = q.wdata;
    assign BUS.wr = q.wr;
    assign BUS.rd = q.rd;
    assign USR_READY = (q.st == HS_IDLE);
    assign USR_RDATA = q.rdata;
    assign USR_RVALID = q.rvalid;
    assign USR_IRQ = BUS.irq;

endmodule

// ### tb/pcrc_monitor.sv
// Concurrent checks on the register bus between the two CRC engine ends
`timescale 1ns/1ps
module pcrc_monitor
    import pcrc_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Shadow of mode bits and step length
    // ------------------------------------------------------------
    logic [6:0] cfg_q; // Last written mode and enable bits
    logic [5:0] cnt_q; // Cycles left in the running step

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    // Step length follows the width field: 8 per byte plus two
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            cfg_q <= 7'h00;
            cnt_q <= 6'h00;
        end
        else
        begin
            if (wr && addr == PCRC_OFS_CONFIG)
                cfg_q <= wdata[6:0];
            if (wr && addr == PCRC_OFS_INPUT && cnt_q == 6'h00)
                cnt_q <= {1'b0, cfg_q[1:0], 3'h0} + 6'h0a;
            else if (cnt_q != 6'h00)
                cnt_q <= cnt_q - 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------
    // Last cycle of a step with the interrupt enabled
    sequence s_last;
        cnt_q == 6'h01 && cfg_q[6] && !(wr && addr == PCRC_OFS_CONFIG);
    endsequence
    // Read of the config register
    sequence s_cfg_read;
        rd && addr == PCRC_OFS_CONFIG;
    endsequence

    a_rdata_rest_zero: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_strobes_apart: assert property (!(wr && rd))
        else $error("write and read strobes together");
    a_input_reads_zero: assert property (rd && addr == PCRC_OFS_INPUT |=> rdata == 32'h0)
        else $error("input word register readable");
    a_config_readback: assert property (s_cfg_read |=>
        rdata[6:0] == $past(cfg_q) && rdata[8] == ($past(cnt_q) != 6'h00))
        else $error("config readback or busy flag wrong");
    a_step_spacing: assert property (wr && addr == PCRC_OFS_INPUT |-> cnt_q == 6'h00)
        else $error("input word written during a step");
    a_irq_needs_enable: assert property (irq |-> cfg_q[6])
        else $error("interrupt while disabled");
    a_irq_on_finish: assert property (s_last |=> irq)
        else $error("no interrupt at step end");
    a_irq_rise_finish: assert property ($rose(irq) && $stable(cfg_q[6])
        |-> $past(cnt_q) == 6'h01)
        else $error("interrupt rose away from step end");
    a_irq_clear_off: assert property (wr && addr == PCRC_OFS_CONFIG
        && (!wdata[6] || (wdata[7] && cnt_q == 6'h00)) |=> !irq)
        else $error("interrupt not cleared");
endmodule

// ### tb/programmable_crc_engine_test.sv
// Self-checking bench driving the host user port of the CRC engine pair
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); \
        end \
    end
module programmable_crc_engine_test
    import pcrc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam logic [31:0] GEN = 32'h04c11db7; // Top aligned generator
    localparam logic [31:0] SEED = 32'hffffffff; // Start value
    logic MCLK;
    logic SYS_RST = 1'b1;
    logic USR_WR = 1'b0;
    logic USR_RD = 1'b0;
    logic [7:0] USR_ADDR = 8'h00;
    logic [31:0] USR_WDATA = 32'h0;
    logic USR_READY, USR_RVALID, USR_IRQ, IRQ, BUSY;
    logic [31:0] USR_RDATA;
    logic [31:0] v; // Last read value
    int n; // Busy cycle count
    int failures = 0;
    int checked = 0;

    pcrc_if i_pcrc_if();
    pcrc_device i_pcrc_device (.MCLK(MCLK), .SYS_RST(SYS_RST), .BUS(i_pcrc_if), .IRQ(IRQ),
        .BUSY(BUSY));
    pcrc_host i_pcrc_host (.MCLK(MCLK), .SYS_RST(SYS_RST), .BUS(i_pcrc_if), .USR_WR(USR_WR),
        .USR_RD(USR_RD), .USR_ADDR(USR_ADDR), .USR_WDATA(USR_WDATA), .USR_READY(USR_READY),
        .USR_RDATA(USR_RDATA), .USR_RVALID(USR_RVALID), .USR_IRQ(USR_IRQ));
    pcrc_monitor i_pcrc_monitor (.MCLK(MCLK), .SYS_RST(SYS_RST), .addr(i_pcrc_if.addr),
        .wdata(i_pcrc_if.wdata), .wr(i_pcrc_if.wr), .rd(i_pcrc_if.rd),
        .rdata(i_pcrc_if.rdata), .irq(i_pcrc_if.irq));

    // Free running clock
    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    // One step: bytes by endianness, bits by bit order, MSB-first LFSR
    function automatic logic [31:0] cstep(logic [31:0] s, logic [31:0] d, int w,
        logic [1:0] io);
        logic [7:0] b;
        logic fb;
        for (int i = 0; i <= w; i++)
        begin
            b = io[0] ? d[8 * i +: 8] : d[8 * (w - i) +: 8];
            for (int j = 0; j < 8; j++)
            begin
                fb = s[31] ^ (io[1] ? b[j] : b[7 - j]);
                s = {s[30:0], 1'b0} ^ (fb ? GEN : 32'h0);
            end
        end
        return s;
    endfunction

    // Output reorder: bit0 swaps bytes, bit1 mirrors bits in each byte
    function automatic logic [31:0] oconv(logic [31:0] s, logic [1:0] fo);
        logic [31:0] r;
        r = fo[0] ? {s[7:0], s[15:8], s[23:16], s[31:24]} : s;
        if (fo[1])
            for (int k = 0; k < 32; k++)
                s[k] = r[(k & 24) + 7 - (k & 7)];
        else
            s = r;
        return s;
    endfunction

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    // Verdict and end of run
    task automatic close_out();
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // A wait that ran out ends the run
    task automatic bound(input int k);
        if (k >= 300)
        begin
            failures++;
            close_out();
        end
    endtask

    // One user request once the host is idle
    task automatic req(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(negedge MCLK);
        while (USR_READY !== 1'b1 && k < 300)
        begin
            @(negedge MCLK);
            k++;
        end
        bound(k);
        @(posedge MCLK);
        USR_WR <= w;
        USR_RD <= !w;
        USR_ADDR <= a;
        USR_WDATA <= d;
        @(posedge MCLK);
        USR_WR <= 1'b0;
        USR_RD <= 1'b0;
    endtask

    // Read and wait for the answer
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int k;
        req(1'b0, a, 32'h0);
        k = 0;
        while (USR_RVALID !== 1'b1 && k < 300)
        begin
            @(negedge MCLK);
            k++;
        end
        bound(k);
        d = USR_RDATA;
    endtask

    // Input word, then count the cycles of busy
    task automatic run(input logic [31:0] d, output int c);
        int k;
        req(1'b1, PCRC_OFS_INPUT, d);
        k = 0;
        c = 0;
        while (BUSY !== 1'b1 && k < 300)
        begin
            @(negedge MCLK);
            k++;
        end
        bound(k);
        while (BUSY === 1'b1 && c < 300)
        begin
            @(negedge MCLK);
            c++;
        end
        bound(c);
    endtask

    // Mode, generator, final xor and seed for a new calculation
    task automatic setup(input logic [31:0] cfg, input logic [31:0] x);
        req(1'b1, PCRC_OFS_CONFIG, cfg);
        req(1'b1, PCRC_OFS_GENERATOR, GEN);
        req(1'b1, PCRC_OFS_FINAL_XOR, x);
        req(1'b1, PCRC_OFS_INITIAL, SEED);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, write-only and unmapped places
    task automatic t_reset();
        rd(PCRC_OFS_CONFIG, v);
        `CHK(v, 32'h0);
        rd(PCRC_OFS_RESULT, v);
        `CHK(v, 32'h0);
        rd(PCRC_OFS_INPUT, v);
        `CHK(v, 32'h0);
        rd(8'h3c, v);
        `CHK(v, 32'h0);
    endtask

    // Every width: step length and value
    task automatic t_widths();
        for (int w = 0; w < 4; w++)
        begin
            setup(w, 32'h0);
            run(32'h8d1235c7, n);
            `CHK(n, 8 * w + 10);
            rd(PCRC_OFS_RESULT, v);
            `CHK(v, cstep(SEED, 32'h8d1235c7, w, 2'h0));
        end
    endtask

    // All input and output orders on a 16-bit word
    task automatic t_orders();
        logic [3:0] s;
        logic [31:0] e; // Expected result
        for (int i = 0; i < 16; i++)
        begin
            s = i[3:0];
            setup({26'h0, s, 2'h1}, 32'ha5a55a5a);
            run(32'h00001235, n);
            rd(PCRC_OFS_RESULT, v);
            e = oconv(cstep(SEED, 32'h1235, 1, s[1:0]), s[3:2]) ^ 32'ha5a55a5a;
            `CHK(v, e);
        end
    endtask

    // Two bytes extend one running value
    task automatic t_chain();
        setup(32'h0, 32'h0);
        // First word without waiting, so the status read lands mid-step
        req(1'b1, PCRC_OFS_INPUT, 32'h31);
        rd(PCRC_OFS_CONFIG, v);
        `CHK(v[8], 1'b1);
        repeat (20) @(negedge MCLK);
        run(32'h32, n);
        `CHK(n, 10);
        rd(PCRC_OFS_RESULT, v);
        `CHK(v, cstep(cstep(SEED, 32'h31, 0, 2'h0), 32'h32, 0, 2'h0));
    endtask

    // Interrupt raised, cleared by done write, then by disable
    task automatic t_irq();
        // Enable, and clear a done flag left by earlier steps
        setup(32'hc0, 32'h0);
        `CHK(USR_IRQ, 1'b0);
        run(32'h5a, n);
        `CHK(USR_IRQ, 1'b1);
        rd(PCRC_OFS_CONFIG, v);
        `CHK(v[7], 1'b1);
        req(1'b1, PCRC_OFS_CONFIG, 32'hc0);
        repeat (2) @(negedge MCLK);
        `CHK(IRQ, 1'b0);
        run(32'h5b, n);
        `CHK(IRQ, 1'b1);
        req(1'b1, PCRC_OFS_CONFIG, 32'h00);
        repeat (2) @(negedge MCLK);
        `CHK(USR_IRQ, 1'b0);
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge MCLK);
        SYS_RST <= 1'b0;
        t_reset();
        t_widths();
        t_orders();
        t_chain();
        t_irq();
        close_out();
    end
endmodule
